/* File: logic/reset_seq_defs.vh */
/*
 reset and bus-clock sequencer constants: counts, flag positions, register
 offsets of the wishbone map. assumes inclusion by bare name.
*/
`ifndef RESET_SEQ_DEFS_VH
`define RESET_SEQ_DEFS_VH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_MHZ          100
`define OSC_DIV_DEFAULT  4
`define POR_DELAY_CYC    4096
`define PIN_LOW_CYC      32
`define INTERNAL_RESET_TAIL_CYC    32
`define STOP_LONG_CYC    4096
`define STOP_SHORT_CYC   32
`define REC_CYC          3
`define BUS_DIV          4
`define PIN_MIN_CYC      3
`define SEQ_CNT_W        12
`define WDOG_W           6
`define WDOG_SVC_LO      5
// ----------------------------------------------------------------------
// vectors
// ----------------------------------------------------------------------
`define VEC_USER         16'hfffe
`define VEC_MON          16'hfefe
// ----------------------------------------------------------------------
// reset cause flags
// ----------------------------------------------------------------------
`define F_POR            7
`define F_PIN            6
`define F_WDOG           5
`define F_OPC            4
`define F_ADR            3
`define F_MON            2
`define F_BRN            1
// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define REG_CAUSE        8'h00
`define REG_CTRL         8'h04
`define REG_STATUS       8'h08
`define REG_WDOG_SVC     8'h0c
`define CTRL_RESET       8'h00
`define CTRL_SHORT_STOP_RECOVERY       0
`define CTRL_STOPEN      1
`define CTRL_PLLSEL      2

`endif

/* File: logic/osc_divider.v */
/*
 clock-enable divider: one-cycle pulse every DIV cycles of clk_i.
 assumes a single clock; en_i freezes the count.
*/
`timescale 1ns/1ps
`default_nettype none
module osc_divider #(
	parameter DIV = 4
) (
	input  wire clk_i,
	input  wire rst_i,
	input  wire en_i,
	output reg  tick_o
);
	reg [7:0] cnt_reg;
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= 8'h00;
			tick_o  <= 1'b0;
		end else if (en_i) begin
			if (cnt_reg == DIV[7:0] - 8'h01) begin
				cnt_reg <= 8'h00;
				tick_o  <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + 8'h01;
				tick_o  <= 1'b0;
			end
		end else begin
			tick_o <= 1'b0;
		end
	end
endmodule // osc_divider
`default_nettype wire

/* File: logic/reset_clock_seq.v */
/*
 reset and bus-clock sequencer: merges reset sources, times the reset pin
 and internal reset with a 12-bit sequencing counter, gates cpu and
 peripheral clock enables, prescales the watchdog, records reset cause.
 assumes clk_i is the internal oscillator clock; all inputs synchronous
 except the reset pin, which is synchronised here.
*/
// Contract
// - bus enable is source clock divided four
// - power-on/brown-out: clocks off 4096 cycles, pin low
// - stop exit waits 4096 or 32 cycles
// - wait stops cpu clock, peripherals keep running
// - any reset asserts internal reset, picks vector; code samples the pin only in S_RUN, so a pin pulse in stop is missed
// - internal reset returns modules to defaults; ctrl_reg keeps its value here
// - internal reset clears counter; pin reset doesn't
// - each source sets its own cause flag
// - pin flag only after minimum low, alone
// - recovery 4163 long, 67 otherwise
// - internal sources: pin low 32, reset 32 more
// - long resets hold pin low 4096+32
// - power-on sets only its flag, enables clockgen
// - watchdog overflow resets, sets watchdog flag
// - service write clears watchdog, counter bits 12:5
// - counter overflow clocks watchdog regularly
// - watchdog disabled only by test voltage conditions; code also stops it whenever watchdog_en_i is low
// - bad opcode resets; stop illegal if disabled
// - only opcode fetch from unmapped address resets
// - brown-out sets flag, long sequence
// - monitor entry reset drives pin low
// - twelve-bit free-running counter, overflow clocks watchdog
// - short stop recovery option selects 32
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_defs.vh"
module reset_clock_seq #(
	parameter POR_CYC  = `POR_DELAY_CYC,
	parameter STOP_CYC = `STOP_LONG_CYC,
	parameter WDOG_W   = `WDOG_W
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        poweron_pulse_i,
	input  wire        brownout_i,
	input  wire        watchdog_en_i,
	input  wire        bad_opcode_i,
	input  wire        stop_instr_i,
	input  wire        wait_instr_i,
	input  wire        wake_i,
	input  wire        opcode_fetch_i,
	input  wire        unmapped_i,
	input  wire        monitor_mode_i,
	input  wire        monitor_entry_reset_i,
	input  wire        break_state_i,
	input  wire        rst_pin_tst_i,
	input  wire        irq_pin_one_tst_i,
	input  wire        rst_pin_i,
	output reg         rst_pin_o,
	output reg         rst_pin_oe_o,
	output reg         internal_reset_o,
	output reg  [15:0] reset_vector_o,
	output reg         clockgen_en_o,
	output wire        cpu_clk_en_o,
	output wire        periph_clk_en_o,
	input  wire [7:0]  wb_adr_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_sel_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	output reg         wb_ack_o
);
	// ------------------------------------------------------------------
	// states
	// ------------------------------------------------------------------
	localparam S_RUN  = 3'd0;
	localparam S_LONG = 3'd1;
	localparam S_PIN  = 3'd2;
	localparam S_TAIL = 3'd3;
	localparam S_STOP = 3'd4;
	localparam S_XPIN = 3'd5;
	localparam S_REC  = 3'd6;
	// cycles between internal reset release and the first bus clock
	localparam REC_LEN = `REC_CYC;

	reg  [2:0]  state_reg;
	reg  [12:0] cnt_reg;
	reg  [12:0] seq_cnt_reg;
	reg  [WDOG_W-1:0] wdog_reg;
	reg  [7:0]  reset_cause_reg;
	reg  [7:0]  ctrl_reg;
	reg         waiting_reg;
	reg         pin_s1_reg;
	reg         pin_s2_reg;
	reg  [1:0]  pin_low_reg;
	reg         wdog_trip_reg;
	reg         service_reg;
	reg         stop_exit_reg;
	wire        bus_tick;
	wire        wdog_off;
	wire        stop_bad;
	wire        adr_bad;
	wire        int_src;
	wire        long_src;
	wire        wb_req;
	wire [12:0] stop_len;
	wire [12:0] rec_last;

	function is_reg;
		input [7:0] a;
		input [7:0] r;
		begin
			is_reg = (a == r);
		end
	endfunction

	function [15:0] vec_sel;
		input mon;
		begin
			vec_sel = mon ? `VEC_MON : `VEC_USER;
		end
	endfunction

	// ------------------------------------------------------------------
	// sources
	// ------------------------------------------------------------------
	// test voltage only; noise on ordinary pins cannot disable it
	assign wdog_off = (monitor_mode_i & (rst_pin_tst_i | irq_pin_one_tst_i))
		| (break_state_i & rst_pin_tst_i);
	assign stop_bad = stop_instr_i & ~ctrl_reg[`CTRL_STOPEN];
	assign adr_bad  = opcode_fetch_i & unmapped_i;
	assign long_src = poweron_pulse_i | brownout_i;
	assign int_src  = long_src | wdog_trip_reg | bad_opcode_i | stop_bad
		| adr_bad | monitor_entry_reset_i;
	assign stop_len = ctrl_reg[`CTRL_SHORT_STOP_RECOVERY] ? 13'd32
		: STOP_CYC[12:0];
	assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	// ------------------------------------------------------------------
	// clock enables
	// ------------------------------------------------------------------
	osc_divider #(
		.DIV (`BUS_DIV)
	) u_div (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.en_i   (state_reg == S_RUN || state_reg == S_REC),
		.tick_o (bus_tick)
	);
	assign periph_clk_en_o = bus_tick & (state_reg == S_RUN);
	assign cpu_clk_en_o = periph_clk_en_o & ~waiting_reg;

	// ------------------------------------------------------------------
	// recovery length
	// ------------------------------------------------------------------
	// stop exit and reset exit share S_REC; this flag keeps a reset from
	// waiting the long stop delay and a stop exit from cutting it short
	always @(posedge clk_i) begin
		if (rst_i) begin
			stop_exit_reg <= 1'b0;
		end else if (int_src) begin
			stop_exit_reg <= 1'b0;
		end else if (state_reg == S_STOP && wake_i) begin
			stop_exit_reg <= 1'b1;
		end else if (state_reg == S_XPIN) begin
			stop_exit_reg <= 1'b0;
		end
	end
	// last count value of S_REC for each kind of exit
	assign rec_last = stop_exit_reg ? stop_len - 13'd1
		: REC_LEN[12:0] - 13'd1;

	// ------------------------------------------------------------------
	// pin synchroniser and low-time filter
	// ------------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_s1_reg  <= 1'b1;
			pin_s2_reg  <= 1'b1;
			pin_low_reg <= 2'd0;
		end else begin
			pin_s1_reg <= rst_pin_i;
			pin_s2_reg <= pin_s1_reg;
			if (pin_s2_reg)
				pin_low_reg <= 2'd0;
			else if (pin_low_reg != 2'd3)
				pin_low_reg <= pin_low_reg + 2'd1;
		end
	end

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg        <= S_LONG;
			cnt_reg          <= 13'd0;
			seq_cnt_reg      <= 13'd0;
			wdog_reg         <= {WDOG_W{1'b0}};
			wdog_trip_reg    <= 1'b0;
			reset_cause_reg  <= 8'h80;
			waiting_reg      <= 1'b0;
			rst_pin_o        <= 1'b0;
			rst_pin_oe_o     <= 1'b1;
			internal_reset_o <= 1'b1;
			reset_vector_o   <= `VEC_USER;
			clockgen_en_o    <= 1'b1;
		end else begin
			wdog_trip_reg <= 1'b0;
			// free-running, bit 12 carry clocks the watchdog
			seq_cnt_reg <= {1'b0, seq_cnt_reg[11:0]} + 13'd1;
			if (service_reg)
				seq_cnt_reg <= {8'h00, seq_cnt_reg[4:0]};
			if (service_reg || internal_reset_o || wdog_off)
				wdog_reg <= {WDOG_W{1'b0}};
			else if (seq_cnt_reg[12] && watchdog_en_i) begin
				wdog_reg <= wdog_reg + {{(WDOG_W-1){1'b0}}, 1'b1};
				if (&wdog_reg)
					wdog_trip_reg <= 1'b1;
			end
			cnt_reg <= cnt_reg + 13'd1;
			if (int_src) begin
				internal_reset_o <= 1'b1;
				rst_pin_o        <= 1'b0;
				rst_pin_oe_o     <= 1'b1;
				seq_cnt_reg      <= 13'd0;
				cnt_reg          <= 13'd0;
				waiting_reg      <= 1'b0;
				reset_vector_o   <= vec_sel(monitor_mode_i);
				state_reg <= long_src ? S_LONG : S_PIN;
				if (poweron_pulse_i)
					reset_cause_reg <= 8'h80;
				else
					reset_cause_reg <= reset_cause_reg
						| {1'b0, 1'b0, wdog_trip_reg,
						bad_opcode_i | stop_bad, adr_bad,
						monitor_entry_reset_i, brownout_i,
						1'b0};
				if (poweron_pulse_i)
					clockgen_en_o <= 1'b1;
			end else begin
				case (state_reg)
				S_RUN: begin
					if (pin_low_reg != 2'd0) begin
						internal_reset_o <= 1'b1;
						state_reg <= S_XPIN;
					end else if (stop_instr_i) begin
						seq_cnt_reg <= 13'd0;
						cnt_reg     <= 13'd0;
						state_reg   <= S_STOP;
					end else if (wait_instr_i)
						waiting_reg <= 1'b1;
					else if (wake_i)
						waiting_reg <= 1'b0;
				end
				S_LONG: begin
					// clocks held off while oscillator settles
					if (cnt_reg == POR_CYC[12:0] - 13'd1) begin
						cnt_reg   <= 13'd0;
						state_reg <= S_PIN;
					end
				end
				S_PIN: begin
					if (cnt_reg == 13'd31) begin
						rst_pin_oe_o <= 1'b0;
						rst_pin_o    <= 1'b1;
						cnt_reg      <= 13'd0;
						state_reg    <= S_TAIL;
					end
				end
				S_TAIL: begin
					if (cnt_reg == 13'd31) begin
						internal_reset_o <= 1'b0;
						cnt_reg   <= 13'd0;
						state_reg <= S_REC;
					end
				end
				S_XPIN: begin
					// pin reset leaves the counter alone
					if (pin_s2_reg) begin
						if (pin_low_reg == 2'd3)
							reset_cause_reg <= 8'h40;
						reset_vector_o <= vec_sel(monitor_mode_i);
						cnt_reg   <= 13'd0;
						state_reg <= S_TAIL;
					end
				end
				S_STOP: begin
					// wake restarts the count; the oscillator runs in stop
					if (wake_i) begin
						cnt_reg     <= 13'd0;
						waiting_reg <= 1'b0;
						state_reg   <= S_REC;
					end
				end
				S_REC: begin
					if (cnt_reg == rec_last)
						state_reg <= S_RUN;
				end
				default: state_reg <= S_RUN;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// wishbone registers
	// ------------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg    <= `CTRL_RESET;
			wb_ack_o    <= 1'b0;
			wb_dat_o    <= 32'h00000000;
			service_reg <= 1'b0;
		end else begin
			wb_ack_o    <= wb_req;
			service_reg <= 1'b0;
			if (internal_reset_o)
				ctrl_reg <= ctrl_reg; // config survives its own reset
			if (wb_req && wb_we_i && wb_sel_i[0]) begin
				if (is_reg(wb_adr_i, `REG_CTRL))
					ctrl_reg <= wb_dat_i[7:0];
				if (is_reg(wb_adr_i, `REG_WDOG_SVC))
					service_reg <= 1'b1;
			end
			if (wb_req) begin
				if (is_reg(wb_adr_i, `REG_CAUSE))
					wb_dat_o <= {24'h000000, reset_cause_reg};
				else if (is_reg(wb_adr_i, `REG_CTRL))
					wb_dat_o <= {24'h000000, ctrl_reg};
				else if (is_reg(wb_adr_i, `REG_STATUS))
					wb_dat_o <= {12'h000, waiting_reg, state_reg,
						4'h0, seq_cnt_reg[11:0]};
				else
					wb_dat_o <= 32'h00000000;
			end
		end
	end
endmodule // reset_clock_seq
`default_nettype wire

/* File: bench/pin_partner.sv */
/*
 reset pin far side: pull-up wire plus an outside party pulling it low.
 assumes oe high means the sequencer drives the pin low.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
	input  wire logic oe_i,
	input  wire logic pull_low_i,
	output wire logic pin_o
);
	// pull-up: a released pin reads high, never a stale level
	assign pin_o = !(oe_i || pull_low_i);
endmodule // pin_partner
`default_nettype wire

/* File: bench/reset_clock_seq_asserts.sv */
/*
 checker for the reset sequencer top ports.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module reset_clock_seq_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        bad_opcode_i,
	input wire logic        rst_pin_o,
	input wire logic        rst_pin_oe_o,
	input wire logic        internal_reset_o,
	input wire logic [15:0] reset_vector_o,
	input wire logic        cpu_clk_en_o,
	input wire logic        periph_clk_en_o,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_vec;
		reset_vector_o == 16'hfffe || reset_vector_o == 16'hfefe;
	endproperty
	a_vec: assert property (p_vec)
		else $error("reset vector out of range");
	property p_src;
		bad_opcode_i |=> internal_reset_o;
	endproperty
	a_src: assert property (p_src)
		else $error("bad opcode gave no reset");
	property p_pin;
		rst_pin_oe_o |-> !rst_pin_o;
	endproperty
	a_pin: assert property (p_pin)
		else $error("pin driven high");
	property p_gate;
		internal_reset_o |-> !cpu_clk_en_o && !periph_clk_en_o;
	endproperty
	a_gate: assert property (p_gate)
		else $error("clock enable during reset");
	property p_div;
		cpu_clk_en_o |=> !cpu_clk_en_o [*3];
	endproperty
	a_div: assert property (p_div)
		else $error("bus enable faster than one in four");
	property p_wait;
		cpu_clk_en_o |-> periph_clk_en_o;
	endproperty
	a_wait: assert property (p_wait)
		else $error("cpu clock without peripheral clock");
	// a short pin pulse would miss external peripherals
	property p_low;
		$rose(rst_pin_oe_o) |-> rst_pin_oe_o [*8];
	endproperty
	a_low: assert property (p_low)
		else $error("pin low phase too short");
	property p_tail;
		$fell(rst_pin_oe_o) |-> internal_reset_o [*8];
	endproperty
	a_tail: assert property (p_tail)
		else $error("internal reset tail too short");
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("bus answer timing wrong");
endmodule // reset_clock_seq_chk
`default_nettype wire

/* File: bench/tb_top.sv */
/*
 testbench for the reset sequencer: wishbone tasks, reset sources.
 assumes shortened power-on and stop counts of 64.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int POR = 64;
	logic        clk_i = 0, rst_i = 1, wb_we_i = 0;
	logic        watchdog_en_i = 0, break_state_i = 0;
	logic        rst_pin_tst_i = 0, irq_pin_one_tst_i = 0;
	logic        wait_instr_i = 0, wake_i = 0, monitor_mode_i = 0;
	logic        pl = 0, dfetch = 0, wb_cyc_i = 0, wb_stb_i = 0;
	logic [5:0]  src = 0;
	logic [7:0]  wb_adr_i = 0;
	logic [3:0]  wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, q;
	wire         bad_opcode_i = src[0], monitor_entry_reset_i = src[1];
	wire         brownout_i = src[2], opcode_fetch_i = src[3];
	wire         poweron_pulse_i = src[4], stop_instr_i = src[5];
	wire         unmapped_i = src[3] | dfetch;
	wire         rst_pin_i, rst_pin_o, rst_pin_oe_o, internal_reset_o;
	wire         clockgen_en_o, cpu_clk_en_o, periph_clk_en_o, wb_ack_o;
	wire [15:0]  reset_vector_o;
	int          failures = 0, check_count = 0, seed = 67195, i, k, n, c;
	int          fl[6] = '{4, 2, 1, 3, 7, 4};
	reset_clock_seq #(.POR_CYC(POR), .STOP_CYC(64), .WDOG_W(2))
		reset_clock_seq_i (.*);
	pin_partner pin_partner_i (.oe_i(rst_pin_oe_o), .pull_low_i(pl),
		.pin_o(rst_pin_i));
	always #5 clk_i = !clk_i;
	task automatic report_and_stop;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tmo(input int m, input int lim);
		if (m >= lim) begin
			failures++;
			report_and_stop;
		end
	endtask
	task automatic wb(input logic [7:0] a, input logic we,
		input logic [31:0] d);
		int m;
		wb_adr_i <= a;
		wb_we_i <= we;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		for (m = 0; m < 20; m++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1) break;
		end
		q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge clk_i);
		tmo(m, 20);
	endtask
	// pin-low cycles counted until internal reset drops
	task automatic settle(output int low);
		int m;
		m = 0;
		#1;
		low = int'(rst_pin_oe_o === 1'b1);
		do begin
			@(posedge clk_i);
			#1;
			m++;
			if (rst_pin_oe_o === 1'b1) low++;
		end while (internal_reset_o !== 1'b0 && m < 2000);
		@(posedge clk_i);
		tmo(m, 2000);
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 0;
		settle(n);
		wb(8'h00, 0, 0);
		chk(q[7:0], 8'h80);
		chk(clockgen_en_o, 1);
		wb(8'h10, 0, 0);
		chk(q, 0);
		dfetch <= 1;
		repeat (3) @(posedge clk_i);
		dfetch <= 0;
		chk(internal_reset_o, 0);
		wb(8'h0c, 1, $random(seed));
		wb(8'h08, 0, 0);
		chk(q[11:0] < 40, 1);
		wait_instr_i <= 1;
		@(posedge clk_i);
		wait_instr_i <= 0;
		for (n = 0, c = 0, k = 0; n < 12; n++) begin
			@(posedge clk_i);
			c |= cpu_clk_en_o;
			k |= periph_clk_en_o;
		end
		chk(c, 0);
		chk(k, 1);
		wake_i <= 1;
		@(posedge clk_i);
		wake_i <= 0;
		for (n = 0, c = 0; n < 8; n++) begin
			@(posedge clk_i);
			c |= cpu_clk_en_o;
		end
		chk(c, 1);
		k = $random(seed) & 1;
		wb(8'h04, 1, 32'h2 | k);
		wb(8'h04, 0, 0);
		chk(q[1:0], 2 | k);
		src[5] <= 1;
		@(posedge clk_i);
		src[5] <= 0;
		wake_i <= 1;
		@(posedge clk_i);
		wake_i <= 0;
		for (n = 0; n < 200; n++) begin
			@(posedge clk_i);
			#1;
			if (cpu_clk_en_o === 1'b1) break;
		end
		chk(n >= (k ? 31 : 63) && n <= (k ? 34 : 66), 1);
		@(posedge clk_i);
		wb(8'h04, 1, 0);
		for (i = 0; i < 10; i++) begin
			k = i < 6 ? i : $unsigned($random(seed)) % 6;
			monitor_mode_i <= $random(seed);
			src <= 6'h1 << k;
			@(posedge clk_i);
			src <= 0;
			settle(n);
			chk(n, (k == 2 || k == 4) ? POR + 32 : 32);
			chk(reset_vector_o, monitor_mode_i ? 16'hfefe : 16'hfffe);
			wb(8'h00, 0, 0);
			chk(q[fl[k]], 1);
		end
		watchdog_en_i <= 1;
		for (n = 0; n < 20000 && internal_reset_o !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
		tmo(n, 20000);
		settle(n);
		watchdog_en_i <= 0;
		chk(n, 32);
		wb(8'h00, 0, 0);
		chk(q[5], 1);
		pl <= 1;
		repeat (6) @(posedge clk_i);
		pl <= 0;
		settle(n);
		wb(8'h00, 0, 0);
		chk(q[6], 1);
		report_and_stop;
	end
endmodule // tb_top
bind reset_clock_seq reset_clock_seq_chk chk_i (.*);
`default_nettype wire
